// ===== design/cmpa_regs.sv
// Comparator control and status registers with AXI4-Lite slave
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// (R1) Swap exchanges inputs and inverts reported output
// (R2) Reference terminal select, mapping reversed when swapped
// (R3) Two-bit reference level: off, quarter, half, diode
// (R4) Comparator-on powers comparator; reference independent
// (R5) Edge select: 0 rising, 1 falling
// (R6) Filter enable routes output through filter
// (R7) Control-two bit 3 connects pin to input one
// (R8) Control-two bit 2 connects pin to input zero
// (R9) Each disable bit turns off its buffer
// (R10) Disable bit n governs port pin n
// (R11) Result high when plus exceeds minus; off reads low
// (R12) Flag set on edge; cleared by service or software
// (R13) Request needs flag, enable and global enable
// (R14) Result read-only; all else resets zero
module cmpa_regs
  import cmpa_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  // AXI4-Lite read data
  input wire logic s_axi_rvalid_unused_n,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Analog comparator side
  input wire logic raw_decision,
  input wire logic filtered_decision,
  output cmpa_analog_t analog_ctl,
  // Port pins
  output logic [7:0] pin_buffer_en,
  // Processor interrupt side
  input wire logic global_irq_enable,
  input wire logic irq_ack,
  output logic irq_req,
  output logic comparator_result
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:1] ctl1_hi_q;
  logic flag_q;
  logic [7:0] ctl1_q;
  logic [3:0] ctl2_q;
  logic [7:0] pbd_q;
  logic result_q;
  logic result_prev_q;
  logic aw_held_q;
  logic w_held_q;
  logic [11:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  logic do_write;
  logic [11:0] wr_addr;
  logic [7:0] wr_byte;
  logic wr_lane;
  logic wr_ctl1;
  logic wr_ctl2;
  logic wr_pbd;
  logic wr_hit;
  logic result_d;
  logic edge_seen;
  logic [7:0] ctl2_view;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic flag_set;
  logic flag_wr;
  logic flag_clr;
  logic [7:0] rd_byte;
  logic rd_hit;

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;

  assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  assign wr_byte = w_held_q ? wbyte_q : s_axi_wdata[7:0];
  assign wr_lane = w_held_q ? wlane_q : s_axi_wstrb[0];
  // Both halves present, now or earlier
  assign do_write = (aw_held_q || aw_take) && (w_held_q || w_take);
  assign wr_hit = (wr_addr == CMPA_ADDR_CTL1) || (wr_addr == CMPA_ADDR_CTL2) ||
                  (wr_addr == CMPA_ADDR_PBD);
  assign wr_ctl1 = do_write && wr_lane && (wr_addr == CMPA_ADDR_CTL1);
  assign wr_ctl2 = do_write && wr_lane && (wr_addr == CMPA_ADDR_CTL2);
  assign wr_pbd = do_write && wr_lane && (wr_addr == CMPA_ADDR_PBD);

  // Address taken ahead of its data
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      aw_held_q <= 1'b0;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end else if (aw_take) begin
      aw_held_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      awaddr_q <= 12'h000;
    end else if (aw_take && !do_write) begin
      awaddr_q <= s_axi_awaddr;
    end
  end

  // Data taken ahead of its address
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      w_held_q <= 1'b0;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end else if (w_take) begin
      w_held_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
    end else if (w_take && !do_write) begin
      wbyte_q <= s_axi_wdata[7:0];
      wlane_q <= s_axi_wstrb[0];
    end
  end

  // ---------------------------------------------------------------
  // Write response
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bvalid_q <= 1'b0;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bresp_q <= CMPA_RESP_OKAY;
    end else if (do_write) begin
      bresp_q <= wr_hit ? CMPA_RESP_OKAY : CMPA_RESP_SLVERR;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // (R14) Zero after reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctl1_hi_q <= CMPA_RST_REG[7:1];
    end else if (wr_ctl1) begin
      ctl1_hi_q <= wr_byte[7:1];
    end
  end

  // (R14) Result bit not writable
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctl2_q <= CMPA_RST_REG[3:0];
    end else if (wr_ctl2) begin
      ctl2_q <= wr_byte[3:0];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pbd_q <= CMPA_RST_REG;
    end else if (wr_pbd) begin
      pbd_q <= wr_byte;
    end
  end

  // ---------------------------------------------------------------
  // Comparator result and edge
  // ---------------------------------------------------------------
  // (R11) (R1) (R6) Off reads low, swap inverts, filter selects
  always_comb begin
    result_d = ctl2_q[CMPA_B_FILT] ? filtered_decision : raw_decision;
    result_d = result_d ^ ctl1_q[CMPA_B_SWAP];
    result_d = result_d && ctl1_q[CMPA_B_ON];
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      result_q <= 1'b0;
    end else begin
      result_q <= result_d;
    end
  end

  // Previous result for edge detection
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      result_prev_q <= 1'b0;
    end else begin
      result_prev_q <= result_q;
    end
  end

  // (R5) Rising or falling edge
  assign edge_seen = ctl1_q[CMPA_B_IES] ? (result_prev_q && !result_q) :
                                         (!result_prev_q && result_q);

  assign comparator_result = result_q;

  // ---------------------------------------------------------------
  // Interrupt flag and request
  // ---------------------------------------------------------------
  assign flag_set = edge_seen;
  assign flag_wr = wr_ctl1;
  assign flag_clr = irq_ack;

  // (R12) Edge sets flag, set beats clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else if (flag_set) begin
      flag_q <= 1'b1;
    end else if (flag_wr) begin
      flag_q <= wr_byte[CMPA_B_IFG];
    end else if (flag_clr) begin
      flag_q <= 1'b0;
    end
  end

  assign ctl1_q = {ctl1_hi_q, flag_q};

  // (R13) Gated request
  assign irq_req = flag_q && ctl1_q[CMPA_B_IE] && global_irq_enable;

  // ---------------------------------------------------------------
  // Analog controls
  // ---------------------------------------------------------------
  always_comb begin
    // (R4) Power bit
    analog_ctl.comparator_on = ctl1_q[CMPA_B_ON];
    // (R1) Input exchange
    analog_ctl.input_swap = ctl1_q[CMPA_B_SWAP];
    // (R2) Reference terminal mapping
    analog_ctl.ref_to_plus = !(ctl1_q[CMPA_B_RSEL] ^ ctl1_q[CMPA_B_SWAP]);
    analog_ctl.ref_to_minus = ctl1_q[CMPA_B_RSEL] ^ ctl1_q[CMPA_B_SWAP];
    // (R3) Level code, off disables generator
    analog_ctl.ref_level_sel = cmpa_ref_t'(ctl1_q[CMPA_B_REFHI:CMPA_B_REFLO]);
    analog_ctl.ref_enable = (ctl1_q[CMPA_B_REFHI:CMPA_B_REFLO] != CMPA_REF_OFF);
    // (R6) Filter select
    analog_ctl.output_filter_en = ctl2_q[CMPA_B_FILT];
    // (R7) Pin to input one
    analog_ctl.pin_to_input_one = ctl2_q[CMPA_B_PIN1];
    // (R8) Pin to input zero
    analog_ctl.pin_to_input_zero = ctl2_q[CMPA_B_PIN0];
  end

  // ---------------------------------------------------------------
  // Port buffer enables
  // ---------------------------------------------------------------
  // (R9) (R10) Buffer n from bit n
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pbd
      assign pin_buffer_en[gi] = !pbd_q[gi];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  assign s_axi_arready = !rvalid_q;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign ctl2_view = {4'h0, ctl2_q[3:1], result_q};

  // Unmapped addresses read zero
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      CMPA_ADDR_CTL1: rd_byte = ctl1_q;
      CMPA_ADDR_CTL2: rd_byte = ctl2_view;
      CMPA_ADDR_PBD: rd_byte = pbd_q;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rvalid_q <= 1'b0;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h00000000;
      rresp_q <= CMPA_RESP_OKAY;
    end else if (ar_take) begin
      rdata_q <= {24'h000000, rd_byte};
      rresp_q <= rd_hit ? CMPA_RESP_OKAY : CMPA_RESP_SLVERR;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule

// ===== design/cmpa_pkg.sv
// Package: register map, field positions, response codes and analog-side types for the comparator control block
package cmpa_pkg;

  // ---------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] CMPA_IDX_CTL1 = 8'h59;
  localparam logic [7:0] CMPA_IDX_CTL2 = 8'h5a;
  localparam logic [7:0] CMPA_IDX_PBD = 8'h5b;
  localparam logic [11:0] CMPA_ADDR_CTL1 = {2'h0, CMPA_IDX_CTL1, 2'h0};
  localparam logic [11:0] CMPA_ADDR_CTL2 = {2'h0, CMPA_IDX_CTL2, 2'h0};
  localparam logic [11:0] CMPA_ADDR_PBD = {2'h0, CMPA_IDX_PBD, 2'h0};

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CMPA_B_SWAP = 7;
  localparam int CMPA_B_RSEL = 6;
  localparam int CMPA_B_REFHI = 5;
  localparam int CMPA_B_REFLO = 4;
  localparam int CMPA_B_ON = 3;
  localparam int CMPA_B_IES = 2;
  localparam int CMPA_B_IE = 1;
  localparam int CMPA_B_IFG = 0;
  localparam int CMPA_B_PIN1 = 3;
  localparam int CMPA_B_PIN0 = 2;
  localparam int CMPA_B_FILT = 1;
  localparam int CMPA_B_RES = 0;

  // ---------------------------------------------------------------
  // Reset values and responses
  // ---------------------------------------------------------------
  localparam logic [7:0] CMPA_RST_REG = 8'h00;
  localparam logic [1:0] CMPA_RESP_OKAY = 2'h0;
  localparam logic [1:0] CMPA_RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Reference level codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CMPA_REF_OFF = 2'b00,
    CMPA_REF_QUARTER = 2'b01,
    CMPA_REF_HALF = 2'b10,
    CMPA_REF_DIODE = 2'b11
  } cmpa_ref_t;

  // ---------------------------------------------------------------
  // Analog-side controls
  // ---------------------------------------------------------------
  typedef struct packed {
    logic comparator_on;
    logic input_swap;
    logic ref_to_plus;
    logic ref_to_minus;
    logic ref_enable;
    cmpa_ref_t ref_level_sel;
    logic output_filter_en;
    logic pin_to_input_one;
    logic pin_to_input_zero;
  } cmpa_analog_t;

endpackage

// ===== testbench/cmpa_regs_props.sv
// Checker for the comparator control register block
`timescale 1ns/1ps
module cmpa_props
  import cmpa_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register write side
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // Comparator, port and interrupt side
  input wire logic raw_decision,
  input wire logic filtered_decision,
  input wire cmpa_analog_t analog_ctl,
  input wire logic [7:0] pin_buffer_en,
  input wire logic global_irq_enable,
  input wire logic irq_req,
  input wire logic comparator_result
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  logic wr_go;
  logic exp_res;
  logic [7:0] wd_q;
  assign wr_go = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready & s_axi_wstrb[0];
  assign exp_res = analog_ctl.comparator_on
    & ((analog_ctl.output_filter_en ? filtered_decision : raw_decision) ^ analog_ctl.input_swap);
  // Last byte of a lane-0 write whose address and data are taken in the same cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wd_q <= 8'h00;
    end else if (wr_go) begin
      wd_q <= s_axi_wdata[7:0];
    end
  end
  // ----
  // Assertions
  // ----
  property p_ref_pair;
    analog_ctl.ref_to_plus != analog_ctl.ref_to_minus;
  endproperty
  a_ref_pair: assert property (p_ref_pair)
    else $error("reference routing broken");
  property p_ref_en;
    analog_ctl.ref_enable == (analog_ctl.ref_level_sel != CMPA_REF_OFF);
  endproperty
  a_ref_en: assert property (p_ref_en)
    else $error("reference enable wrong");
  property p_off_low;
    !analog_ctl.comparator_on |=> !comparator_result;
  endproperty
  a_off_low: assert property (p_off_low)
    else $error("result high while off");
  property p_result;
    1'b1 |=> comparator_result == $past(exp_res);
  endproperty
  a_result: assert property (p_result)
    else $error("result wrong");
  property p_irq_gate;
    !global_irq_enable |-> !irq_req;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("request without global enable");
  property p_irq_edge;
    $rose(irq_req) && !$past(wr_go) && !$rose(global_irq_enable)
      |-> $past(comparator_result) != $past(comparator_result, 2);
  endproperty
  a_irq_edge: assert property (p_irq_edge)
    else $error("flag set without edge");
  property p_pbd_wr;
    wr_go && s_axi_awaddr == CMPA_ADDR_PBD |-> ##[1:2] pin_buffer_en == ~wd_q;
  endproperty
  a_pbd_wr: assert property (p_pbd_wr)
    else $error("buffer enables wrong");
  property p_ctl2_wr;
    wr_go && s_axi_awaddr == CMPA_ADDR_CTL2 |-> ##[1:2] {analog_ctl.pin_to_input_one,
      analog_ctl.pin_to_input_zero, analog_ctl.output_filter_en} == wd_q[3:1];
  endproperty
  a_ctl2_wr: assert property (p_ctl2_wr)
    else $error("pin or filter control wrong");
  property p_ctl1_wr;
    wr_go && s_axi_awaddr == CMPA_ADDR_CTL1 |-> ##1 analog_ctl.input_swap == wd_q[7] &&
      analog_ctl.ref_to_plus == (wd_q[6] == wd_q[7]) && analog_ctl.comparator_on == wd_q[3] &&
      analog_ctl.ref_level_sel == wd_q[5:4];
  endproperty
  a_ctl1_wr: assert property (p_ctl1_wr)
    else $error("first control fields wrong");
endmodule

bind cmpa_regs cmpa_props i_props (.*);

// ===== testbench/comparator_control_regs_tb_top.sv
// Self-checking testbench for the comparator control registers
`timescale 1ns/1ps
module comparator_control_regs_tb_top
  import cmpa_pkg::*;
();
  localparam logic [1:0] OK = CMPA_RESP_OKAY;
  logic mclk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rready;
  logic s_axi_rvalid_unused_n, s_axi_rvalid, raw_decision, filtered_decision;
  logic global_irq_enable, irq_ack, irq_req, comparator_result;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] pin_buffer_en;
  logic [2:0] pins;
  cmpa_analog_t analog_ctl;
  int error_cnt = 0;
  int comparisons = 0;
  assign pins = {analog_ctl.pin_to_input_one, analog_ctl.pin_to_input_zero,
    analog_ctl.output_filter_en};
  cmpa_regs i_dut (.*);
  always #2.5 mclk = ~mclk;
  // ----
  // Shared tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      error_cnt++;
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    logic pa, pw, ta, tw;
    @(posedge mclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa | pw) begin
      @(negedge mclk);
      ta = pa & s_axi_awready;
      tw = pw & s_axi_wready;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa & !ta;
      pw = pw & !tw;
    end
    do @(negedge mclk); while (!s_axi_bvalid);
    check(32'(s_axi_bresp), 32'(r));
    @(posedge mclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge mclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do @(negedge mclk); while (!s_axi_arready);
    @(posedge mclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge mclk); while (!s_axi_rvalid);
    check(s_axi_rdata, e);
    check(32'(s_axi_rresp), 32'(r));
    @(posedge mclk);
    s_axi_rready <= 1'b0;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    axi_rd(CMPA_ADDR_CTL1, 32'h0, OK);
    axi_rd(CMPA_ADDR_CTL2, 32'h0, OK);
    check(32'(pin_buffer_en), 32'hff);
    axi_wr(CMPA_ADDR_PBD, 8'h5a, OK);
    axi_rd(CMPA_ADDR_PBD, 32'h5a, OK);
    check(32'(pin_buffer_en), 32'ha5);
    axi_wr(CMPA_ADDR_PBD, 8'h01, OK);
    step(0);
    check(32'(pin_buffer_en), 32'hfe);
    @(posedge mclk);
    s_axi_wstrb <= 4'h0;
    axi_wr(CMPA_ADDR_PBD, 8'h33, OK);
    s_axi_wstrb <= 4'h1;
    check(32'(pin_buffer_en), 32'hfe);
    axi_wr(12'h100, 8'hff, CMPA_RESP_SLVERR);
    axi_rd(12'h100, 32'h0, CMPA_RESP_SLVERR);
    check(32'(pin_buffer_en), 32'hfe);
    axi_wr(CMPA_ADDR_CTL2, 8'hff, OK);
    axi_rd(CMPA_ADDR_CTL2, 32'h0e, OK);
    check(32'(pins), 32'h7);
    axi_wr(CMPA_ADDR_CTL2, 8'h04, OK);
    step(0);
    check(32'(pins), 32'h2);
  endtask
  task automatic t_ref;
    logic [3:0] v;
    for (int i = 0; i < 16; i++) begin
      v = 4'(i);
      axi_wr(CMPA_ADDR_CTL1, {v, 4'h0}, OK);
      step(0);
      check(32'(analog_ctl.input_swap), 32'(v[3]));
      check(32'(analog_ctl.ref_to_plus), 32'(v[3] == v[2]));
      check(32'(analog_ctl.ref_level_sel), 32'(v[1:0]));
      check(32'(analog_ctl.ref_enable), 32'(v[1:0] != 2'h0));
      check(32'(analog_ctl.comparator_on), 32'h0);
    end
  endtask
  task automatic t_cmp;
    axi_wr(CMPA_ADDR_CTL2, 8'h00, OK);
    axi_wr(CMPA_ADDR_CTL1, 8'h08, OK);
    raw_decision <= 1'b1;
    step(2);
    check(32'(comparator_result), 32'h1);
    axi_wr(CMPA_ADDR_CTL2, 8'h03, OK);
    axi_rd(CMPA_ADDR_CTL2, 32'h02, OK);
    axi_wr(CMPA_ADDR_CTL1, 8'h88, OK);
    step(2);
    check(32'(comparator_result), 32'h1);
    check(32'(irq_req), 32'h0);
    axi_rd(CMPA_ADDR_CTL1, 32'h89, OK);
    axi_wr(CMPA_ADDR_CTL1, 8'h80, OK);
    step(2);
    check(32'(comparator_result), 32'h0);
  endtask
  task automatic t_irq;
    axi_wr(CMPA_ADDR_CTL2, 8'h00, OK);
    raw_decision <= 1'b0;
    axi_wr(CMPA_ADDR_CTL1, 8'h0a, OK);
    @(posedge mclk);
    raw_decision <= 1'b1;
    step(3);
    check(32'(irq_req), 32'h1);
    @(posedge mclk);
    global_irq_enable <= 1'b0;
    step(0);
    check(32'(irq_req), 32'h0);
    @(posedge mclk);
    global_irq_enable <= 1'b1;
    irq_ack <= 1'b1;
    @(posedge mclk);
    irq_ack <= 1'b0;
    step(0);
    check(32'(irq_req), 32'h0);
    axi_wr(CMPA_ADDR_CTL1, 8'h0e, OK);
    raw_decision <= 1'b0;
    step(3);
    check(32'(irq_req), 32'h1);
    axi_wr(CMPA_ADDR_CTL1, 8'h0e, OK);
    raw_decision <= 1'b1;
    step(3);
    check(32'(irq_req), 32'h0);
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {raw_decision, filtered_decision, irq_ack, s_axi_rvalid_unused_n} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    global_irq_enable = 1'b1;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    t_regs();
    t_ref();
    t_cmp();
    t_irq();
    wrap_up();
  end
  initial begin
    #20000;
    error_cnt++;
    wrap_up();
  end
endmodule
